// *** ssw_host.sv ***
/* host model of command and clear strobes; assumes sampling on mclk */
`timescale 1ns/1ps
module ssw_host (
    input wire logic mclk, // block clock
    output ssw_pkg::ssw_cmd_t cmd = '0, // command strobes
    output ssw_pkg::ssw_flag_t clr = '0 // clear strobes
);
    import ssw_pkg::*;
    // ==========================================================
    // strobes stand one whole cycle, then drop to idle
    task automatic pulse(input ssw_cmd_t c, input ssw_flag_t f);
        @(posedge mclk);
        {cmd, clr} <= {c, f};
        @(posedge mclk);
        {cmd, clr} <= '0;
        #1;
    endtask
    // k: 0 first, 1 second, 2 trigger, 3 ov reset, else mode (v=1 stop)
    task automatic wr(input int k, input logic v);
        ssw_cmd_t c = '0;
        {c.first_val, c.second_val, c.ovr_val} = {3{v}};
        c.mode_sel = ssw_req_t'({1'b0, v});
        case (k)
            0: c.wr_first = 1'b1;
            1: c.wr_second = 1'b1;
            2: c.wdog_trig = 1'b1;
            3: c.wr_ovr = 1'b1;
            default: c.mode_req = 1'b1;
        endcase
        pulse(c, '0);
    endtask
    // ov reset dropped before the disable bits so line noise in stop cannot restart us
    task automatic off_seq();
        wr(4, 1'b0);
        wr(3, 1'b0);
        wr(0, 1'b1);
        wr(1, 1'b1);
        wr(4, 1'b1);
    endtask
endmodule

// *** ssw_pkg.sv ***
/*
 shared constants and carrier types for the supply supervision block.
 assumes a 40 MHz MCLK; every count is derived from a time below.
*/
package ssw_pkg;
    // ==========================================================
    // timing
    localparam int CLK_KHZ = 40_000;
    localparam int T_LW_MS = 200;
    localparam int T_RD_US = 10_000;
    localparam int T_SC_US = 2_000;
    localparam int LW_CYC = T_LW_MS * CLK_KHZ;
    localparam int RD_CYC = T_RD_US * CLK_KHZ / 1000;
    localparam int SC_CYC = T_SC_US * CLK_KHZ / 1000;
    localparam int TW = 23;
    // ==========================================================
    // limits and reset values
    localparam logic [2:0] UV_FS_LIMIT = 3'h4;
    localparam logic BUS_WAKE_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b1;
    localparam logic MAIN_ON_RST = 1'b1;
    // ==========================================================
    // types
    typedef logic [TW-1:0] ssw_tmr_t;
    typedef enum logic [5:0] {
        M_INIT = 6'h01,
        M_NORMAL = 6'h02,
        M_STOP = 6'h04,
        M_SLEEP = 6'h08,
        M_RESTART = 6'h10,
        M_FAILSAFE = 6'h20
    } ssw_mode_t;
    typedef enum logic [1:0] {
        REQ_NORMAL = 2'h0,
        REQ_STOP = 2'h1,
        REQ_SLEEP = 2'h2,
        REQ_SOFT = 2'h3
    } ssw_req_t;
    typedef struct packed {
        logic sup_por_ok, sup_low, hs_low, hs_high, main_warn;
        logic main_low, main_high, aux_ilim, aux_low, sec_low, can_low;
    } ssw_cmp_t;
    typedef struct packed {
        ssw_cmp_t cmp;
        logic config_select_input, can_wake, wake_inputs;
    } ssw_pin_t;
    typedef struct packed {
        logic por, supply_under_flag, highside_supply_under;
        logic highside_supply_over, main_reg_prewarn, main_reg_under;
        logic main_under_failsafe, main_reg_over, main_reg_short;
        logic failure, aux_reg_overcurrent, aux_reg_under;
        logic second_reg_under, transceiver_supply_under;
    } ssw_flag_t;
    typedef struct packed {
        logic wr_first, first_val, wr_second, second_val, wdog_trig;
        logic mode_req;
        ssw_req_t mode_sel;
        logic wr_bus_wake, bus_wake_val, wr_ovr, ovr_val;
    } ssw_cmd_t;
    typedef struct packed {
        ssw_mode_t mode;
        ssw_flag_t flg;
        ssw_pin_t prev;
        ssw_tmr_t rd_tmr, lw_tmr, sc_tmr;
        logic [2:0] uv_cnt;
        logic stop_wdog_off_first, stop_wdog_off_second;
        logic bus_wake_wdog_start, main_over_reset_en, ov_rst, wdog_off;
        logic reset_output_n, fail_outputs, main_on, aux_en;
        logic int_pulse, rxd_low;
    } ssw_st_t;
endpackage

// *** ssw_sync.sv ***
/*
 two-stage synchroniser bank for comparator levels and pins.
 assumes inputs are asynchronous levels; q is the second stage only.
*/
`timescale 1ns/1ps
module ssw_sync #(
    parameter int W = 1 // number of lines
) (
    input wire logic clk, // sampling clock
    input wire logic rst_b, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssw_sync_st_t;
    ssw_sync_st_t st_reg;
    ssw_sync_st_t st_next;

    always_comb begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule

// *** ssw_top.sv ***
/*
 supply supervision, reset release and stop-mode watchdog control.
 assumes comparator levels and pins are asynchronous; commands and
 clear strobes come already decoded from an spi front end on MCLK.
*/
`timescale 1ns/1ps
module ssw_top #(
    parameter int LW_CYCLES = ssw_pkg::LW_CYC, // long open window
    parameter int RD_CYCLES = ssw_pkg::RD_CYC, // reset delay
    parameter int SC_CYCLES = ssw_pkg::SC_CYC // short-circuit time
) (
    input wire logic MCLK, // 40 MHz clock
    input wire logic RST_B, // async reset, active low
    input wire ssw_pkg::ssw_cmp_t CMP, // comparator levels, async
    input wire logic CONFIG_SELECT_INPUT, // config pin, async
    input wire logic CAN_WAKE, // can wake level, async
    input wire logic WAKE_INPUTS, // wake pin level, async
    input wire ssw_pkg::ssw_cmd_t CMD, // decoded host commands
    input wire ssw_pkg::ssw_flag_t CLR, // flag clear strobes
    input wire logic AUX_REG_KEEP_ON, // keep aux on in supply low
    input wire logic LOAD_SHARE_STOP_KEEP, // keep transistor in stop
    input wire logic LOAD_SHARE, // 1 load sharing, 0 stand-alone
    input wire logic AUX_REQ, // aux regulator requested on
    input wire logic AUX_STARTING, // aux turn-on in progress
    input wire logic SECOND_SWITCHING, // second reg turning on/off
    output ssw_pkg::ssw_mode_t MODE, // operating mode
    output ssw_pkg::ssw_flag_t FLAGS, // status flags
    output logic RESET_OUTPUT_N, // reset output, active low
    output logic FAIL_OUTPUTS, // fail outputs active
    output logic MAIN_ON, // main regulator enable
    output logic AUX_EN, // aux regulator / transistor enable
    output logic WDOG_OFF, // watchdog disabled in stop
    output logic LONG_WIN, // long open window running
    output logic INT_PULSE, // interrupt pulse, one cycle
    output logic RXD_LOW, // receive line pulled low
    output logic STOP_WDOG_OFF_FIRST, // first disable bit
    output logic STOP_WDOG_OFF_SECOND, // second disable bit
    output logic BUS_WAKE_WDOG_START, // bus-wake start bit
    output logic MAIN_OVER_RESET_EN, // overvoltage reset enable
    output logic [2:0] UV_COUNT // consecutive undervoltage count
);
    import ssw_pkg::*;

    ssw_st_t st_reg;
    ssw_st_t st_next;
    ssw_pin_t s;
    ssw_pin_t rise;
    ssw_flag_t set;
    ssw_flag_t hold;
    logic act_md, uv_ev, ov_ev, sc_ev, quiet;

    function automatic ssw_st_t st_dflt();
        ssw_st_t d;
        d = '0;
        d.mode = M_INIT;
        d.flg.por = POR_FLAG_RST;
        d.bus_wake_wdog_start = BUS_WAKE_RST;
        d.main_on = MAIN_ON_RST;
        d.rd_tmr = ssw_tmr_t'(RD_CYCLES);
        return d;
    endfunction
    // reset image as a constant, so the async branch loads no logic
    localparam ssw_st_t ST_RST = st_dflt();

    // ==========================================================
    // input synchronisation
    ssw_sync #(.W($bits(ssw_pin_t))) u_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .d({CMP, CONFIG_SELECT_INPUT, CAN_WAKE, WAKE_INPUTS}),
        .q(s)
    );

    // ==========================================================
    // event decode
    assign rise = s & ~st_reg.prev;
    assign act_md = st_reg.mode inside {M_INIT, M_NORMAL, M_STOP};
    // a rail still low while reset is held is no new event (power-up)
    assign uv_ev = rise.cmp.main_low & act_md & st_reg.reset_output_n;
    assign ov_ev = rise.cmp.main_high
        & (st_reg.mode inside {M_INIT, M_NORMAL});
    assign sc_ev = st_reg.sc_tmr == ssw_tmr_t'(SC_CYCLES);
    assign quiet = s.cmp.sup_por_ok & ~uv_ev & ~ov_ev & ~sc_ev;

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.prev = s;
        st_next.int_pulse = 1'b0;
        set = '0;
        hold = '0;
        // flag sets; the clear of any flag still being set waits for the condition to end; the supply and highside flags also have a hold
        set.supply_under_flag = s.cmp.sup_low;
        hold.supply_under_flag = s.cmp.sup_low;
        set.highside_supply_under = s.cmp.hs_low;
        hold.highside_supply_under = s.cmp.hs_low;
        set.highside_supply_over = s.cmp.hs_high;
        hold.highside_supply_over = s.cmp.hs_high;
        set.main_reg_prewarn = s.cmp.main_warn
            & (st_reg.mode != M_SLEEP);
        set.main_reg_under = uv_ev;
        set.main_reg_over = ov_ev;
        set.aux_reg_overcurrent = s.cmp.aux_ilim & ~LOAD_SHARE;
        set.aux_reg_under = s.cmp.aux_low & ~LOAD_SHARE
            & ~AUX_STARTING;
        set.second_reg_under = s.cmp.sec_low & ~SECOND_SWITCHING;
        set.transceiver_supply_under = s.cmp.can_low;

        if (st_reg.lw_tmr != '0) begin
            st_next.lw_tmr = st_reg.lw_tmr - 1'b1;
        end
        // short check cleared while the supply itself is low
        if (st_reg.main_on && s.cmp.main_low && !s.cmp.sup_low) begin
            st_next.sc_tmr = sc_ev ? st_reg.sc_tmr
                : st_reg.sc_tmr + 1'b1;
        end else begin
            st_next.sc_tmr = '0;
        end

        case (st_reg.mode)
            M_INIT, M_RESTART: begin
                if (s.cmp.main_low && !st_reg.ov_rst) begin
                    st_next.rd_tmr = ssw_tmr_t'(RD_CYCLES);
                    st_next.reset_output_n = 1'b0;
                end else if (st_reg.rd_tmr != '0) begin
                    st_next.rd_tmr = st_reg.rd_tmr - 1'b1;
                end else if (!st_reg.reset_output_n) begin
                    st_next.reset_output_n = 1'b1;
                    st_next.lw_tmr = ssw_tmr_t'(LW_CYCLES);
                    if (st_reg.mode == M_RESTART) begin
                        st_next.mode = M_NORMAL;
                        // overvoltage restart returns even if still high
                        if (st_reg.ov_rst) begin
                            st_next.main_over_reset_en = 1'b0;
                            st_next.ov_rst = 1'b0;
                        end
                    end
                end else if (CMD.mode_req && CMD.mode_sel == REQ_NORMAL
                        && st_reg.mode == M_INIT) begin
                    st_next.mode = M_NORMAL;
                end
            end
            M_NORMAL: begin
                if (CMD.wr_first) begin
                    // a repeated start empties the sequence, leaving both bits clear
                    st_next.stop_wdog_off_first = CMD.first_val
                        & ~st_reg.stop_wdog_off_first;
                    if (CMD.first_val && st_reg.stop_wdog_off_first) begin
                        st_next.stop_wdog_off_second = 1'b0;
                    end
                end
                if (CMD.wr_second) begin
                    st_next.stop_wdog_off_second = CMD.second_val
                        & st_reg.stop_wdog_off_first;
                end
                if (CMD.wdog_trig) begin
                    st_next.lw_tmr = '0;
                end
                if (CMD.wr_bus_wake && !st_reg.stop_wdog_off_first) begin
                    st_next.bus_wake_wdog_start = CMD.bus_wake_val;
                end
                if (CMD.wr_ovr) begin
                    st_next.main_over_reset_en = CMD.ovr_val;
                end
                if (CMD.mode_req) begin
                    case (CMD.mode_sel)
                        REQ_STOP: begin
                            st_next.mode = M_STOP;
                            st_next.wdog_off = st_next.stop_wdog_off_first
                                & st_next.stop_wdog_off_second;
                        end
                        REQ_SLEEP: begin
                            st_next.mode = M_SLEEP;
                            st_next.main_on = 1'b0;
                            st_next.reset_output_n = 1'b0;
                        end
                        REQ_SOFT: begin
                            st_next = st_dflt();
                            st_next.flg = st_reg.flg;
                            st_next.prev = s;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (CMD.wdog_trig || CMD.wr_second
                        || (CMD.mode_req && CMD.mode_sel == REQ_NORMAL)) begin
                    st_next.wdog_off = 1'b0;
                    st_next.stop_wdog_off_first = 1'b0;
                    st_next.stop_wdog_off_second = 1'b0;
                    st_next.rxd_low = 1'b0;
                    st_next.lw_tmr = ssw_tmr_t'(LW_CYCLES);
                    if (CMD.mode_req) begin
                        st_next.mode = M_NORMAL;
                    end
                end else if (rise.can_wake && st_reg.wdog_off
                        && st_reg.bus_wake_wdog_start) begin
                    st_next.wdog_off = 1'b0;
                    st_next.stop_wdog_off_first = 1'b0;
                    st_next.stop_wdog_off_second = 1'b0;
                    st_next.lw_tmr = ssw_tmr_t'(LW_CYCLES);
                    st_next.int_pulse = 1'b1;
                    st_next.rxd_low = 1'b1;
                end else if (CMD.mode_req && CMD.mode_sel == REQ_SOFT) begin
                    st_next = st_dflt();
                    st_next.flg = st_reg.flg;
                    st_next.prev = s;
                end
            end
            M_SLEEP, M_FAILSAFE: begin
                // only a can or wake pin edge, or a drop below the power-on level, brings the regulator back
                if (rise.can_wake || rise.wake_inputs) begin
                    st_next.mode = M_RESTART;
                    st_next.main_on = 1'b1;
                    st_next.rd_tmr = ssw_tmr_t'(RD_CYCLES);
                end
            end
            default: begin
                st_next.mode = M_INIT;
            end
        endcase

        if (CLR.main_reg_under) begin
            st_next.uv_cnt = '0;
        end
        if (CLR.failure) begin
            st_next.fail_outputs = 1'b0;
        end
        // faults, lowest priority first
        if (ov_ev && st_reg.main_over_reset_en) begin
            st_next.fail_outputs = 1'b1;
            set.failure = 1'b1;
            st_next.reset_output_n = 1'b0;
            if (s.config_select_input) begin
                st_next.mode = M_RESTART;
                st_next.ov_rst = 1'b1;
                st_next.rd_tmr = ssw_tmr_t'(RD_CYCLES);
            end else begin
                st_next.mode = M_FAILSAFE;
            end
        end
        if (uv_ev) begin
            if (!(st_reg.mode == M_NORMAL && s.cmp.sup_low)) begin
                st_next.uv_cnt = st_next.uv_cnt + 1'b1;
            end
            st_next.reset_output_n = 1'b0;
            st_next.ov_rst = 1'b0;
            if (st_next.uv_cnt == UV_FS_LIMIT) begin
                st_next.mode = M_FAILSAFE;
                set.main_under_failsafe = 1'b1;
            end else begin
                st_next.mode = M_RESTART;
                st_next.rd_tmr = ssw_tmr_t'(RD_CYCLES);
            end
        end
        if (sc_ev) begin
            st_next.mode = M_FAILSAFE;
            st_next.main_on = 1'b0;
            st_next.fail_outputs = 1'b1;
            st_next.reset_output_n = 1'b0;
            set.main_reg_short = 1'b1;
            set.failure = 1'b1;
        end
        if (st_next.mode == M_FAILSAFE && st_reg.mode != M_FAILSAFE) begin
            st_next.uv_cnt = '0;
            st_next.lw_tmr = '0;
        end
        // set wins over a clear in the same cycle
        st_next.flg = (st_next.flg & ~(CLR & ~hold)) | set;
        st_next.aux_en = AUX_REQ
            & ~(s.cmp.sup_low & ~AUX_REG_KEEP_ON)
            & ~(LOAD_SHARE & (st_next.mode == M_STOP)
            & ~LOAD_SHARE_STOP_KEEP);
        // below the power-on level everything starts over
        if (!s.cmp.sup_por_ok) begin
            st_next = st_dflt();
            st_next.prev = s;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    assign MODE = st_reg.mode;
    assign FLAGS = st_reg.flg;
    assign RESET_OUTPUT_N = st_reg.reset_output_n;
    assign FAIL_OUTPUTS = st_reg.fail_outputs;
    assign MAIN_ON = st_reg.main_on;
    assign AUX_EN = st_reg.aux_en;
    assign WDOG_OFF = st_reg.wdog_off;
    assign LONG_WIN = st_reg.lw_tmr != '0;
    assign INT_PULSE = st_reg.int_pulse;
    assign RXD_LOW = st_reg.rxd_low;
    assign STOP_WDOG_OFF_FIRST = st_reg.stop_wdog_off_first;
    assign STOP_WDOG_OFF_SECOND = st_reg.stop_wdog_off_second;
    assign BUS_WAKE_WDOG_START = st_reg.bus_wake_wdog_start;
    assign MAIN_OVER_RESET_EN = st_reg.main_over_reset_en;
    assign UV_COUNT = st_reg.uv_cnt;

    // ==========================================================
    // assertions
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    property p_seq_err;
        st_reg.mode == M_NORMAL && quiet && CMD.wr_second
            && !st_reg.stop_wdog_off_first |=> !STOP_WDOG_OFF_SECOND;
    endproperty
    a_seq_err: assert property (p_seq_err)
        else $error("second bit kept after sequence error");

    property p_stop_reen;
        st_reg.mode == M_STOP && st_reg.wdog_off && quiet
            && CMD.wdog_trig |=> !WDOG_OFF && !STOP_WDOG_OFF_FIRST
            && !STOP_WDOG_OFF_SECOND && LONG_WIN;
    endproperty
    a_stop_reen: assert property (p_stop_reen)
        else $error("stop trigger did not re-enable watchdog");

    property p_bus_wake;
        st_reg.mode == M_STOP && st_reg.wdog_off && quiet
            && st_reg.bus_wake_wdog_start && rise.can_wake
            && !CMD.wdog_trig && !CMD.wr_second && !CMD.mode_req
            |=> INT_PULSE && RXD_LOW && LONG_WIN ##1 !INT_PULSE;
    endproperty
    a_bus_wake: assert property (p_bus_wake)
        else $error("bus wake did not restart watchdog");

    property p_uv_restart;
        uv_ev && s.cmp.sup_por_ok && !sc_ev && st_reg.uv_cnt == 3'h0
            |=> MODE == M_RESTART && !RESET_OUTPUT_N
            && FLAGS.main_reg_under;
    endproperty
    a_uv_restart: assert property (p_uv_restart)
        else $error("undervoltage did not enter restart");

    property p_uv_fs;
        uv_ev && s.cmp.sup_por_ok && !sc_ev && st_reg.uv_cnt == 3'h3
            && !CLR.main_reg_under && !s.cmp.sup_low && !CMD.mode_req
            |=> MODE == M_FAILSAFE && FLAGS.main_under_failsafe
            && UV_COUNT == 3'h0;
    endproperty
    a_uv_fs: assert property (p_uv_fs)
        else $error("fourth undervoltage did not enter fail-safe");

    property p_cnt_clr;
        CLR.main_reg_under && !uv_ev && s.cmp.sup_por_ok |=> UV_COUNT == 3'h0;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("counter not cleared with flag");

    property p_ov_fs;
        ov_ev && st_reg.main_over_reset_en && !s.config_select_input
            && s.cmp.sup_por_ok && !uv_ev && !sc_ev
            |=> MODE == M_FAILSAFE && FAIL_OUTPUTS && FLAGS.main_reg_over;
    endproperty
    a_ov_fs: assert property (p_ov_fs)
        else $error("overvoltage did not enter fail-safe");

    property p_hold_clr;
        FLAGS.supply_under_flag && s.cmp.sup_low && s.cmp.sup_por_ok
            && CLR.supply_under_flag |=> FLAGS.supply_under_flag;
    endproperty
    a_hold_clr: assert property (p_hold_clr)
        else $error("flag cleared while condition active");

    property p_sticky;
        FLAGS.second_reg_under && !CLR.second_reg_under
            && s.cmp.sup_por_ok |=> FLAGS.second_reg_under;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky flag lost without clear");

    property p_por;
        !s.cmp.sup_por_ok |=> MODE == M_INIT && !RESET_OUTPUT_N
            && FLAGS.por && BUS_WAKE_WDOG_START;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on level loss did not reset");

    property p_long_win;
        $rose(RESET_OUTPUT_N) |-> LONG_WIN;
    endproperty
    a_long_win: assert property (p_long_win)
        else $error("reset release without long window");

    c_stop_off: cover property (st_reg.mode == M_STOP && WDOG_OFF);
    c_uv_fs: cover property (FLAGS.main_under_failsafe);
    c_bus_wake: cover property (INT_PULSE && RXD_LOW);
endmodule

// *** ssw_top_tb.sv ***
/* bench for ssw_top with short counts; assumes ssw_host sends commands */
`timescale 1ns/1ps
module ssw_top_tb;
    import ssw_pkg::*;
    localparam int RD = 10;
    logic MCLK = 0, RST_B = 0, CONFIG_SELECT_INPUT = 0, CAN_WAKE = 0;
    logic WAKE_INPUTS = 0, AUX_REG_KEEP_ON = 0, LOAD_SHARE_STOP_KEEP = 0;
    logic LOAD_SHARE = 0, AUX_REQ = 0, AUX_STARTING = 0, seen = 0;
    logic SECOND_SWITCHING = 0, RESET_OUTPUT_N, FAIL_OUTPUTS, MAIN_ON;
    logic AUX_EN, WDOG_OFF, LONG_WIN, INT_PULSE, RXD_LOW;
    logic STOP_WDOG_OFF_FIRST, STOP_WDOG_OFF_SECOND;
    logic BUS_WAKE_WDOG_START, MAIN_OVER_RESET_EN;
    logic [2:0] UV_COUNT;
    ssw_cmp_t CMP = '0;
    ssw_cmd_t CMD;
    ssw_flag_t CLR, FLAGS;
    ssw_mode_t MODE;
    int num_errors = 0, checks_done = 0;
    always #12.5 MCLK = ~MCLK;
    ssw_top #(.LW_CYCLES(40), .RD_CYCLES(RD), .SC_CYCLES(8)) u_ssw_top (
        .MCLK(MCLK), .RST_B(RST_B), .CMP(CMP),
        .CONFIG_SELECT_INPUT(CONFIG_SELECT_INPUT), .CAN_WAKE(CAN_WAKE),
        .WAKE_INPUTS(WAKE_INPUTS), .CMD(CMD), .CLR(CLR),
        .AUX_REG_KEEP_ON(AUX_REG_KEEP_ON),
        .LOAD_SHARE_STOP_KEEP(LOAD_SHARE_STOP_KEEP),
        .LOAD_SHARE(LOAD_SHARE), .AUX_REQ(AUX_REQ),
        .AUX_STARTING(AUX_STARTING), .SECOND_SWITCHING(SECOND_SWITCHING),
        .MODE(MODE), .FLAGS(FLAGS), .RESET_OUTPUT_N(RESET_OUTPUT_N),
        .FAIL_OUTPUTS(FAIL_OUTPUTS), .MAIN_ON(MAIN_ON), .AUX_EN(AUX_EN),
        .WDOG_OFF(WDOG_OFF), .LONG_WIN(LONG_WIN), .INT_PULSE(INT_PULSE),
        .RXD_LOW(RXD_LOW), .STOP_WDOG_OFF_FIRST(STOP_WDOG_OFF_FIRST),
        .STOP_WDOG_OFF_SECOND(STOP_WDOG_OFF_SECOND),
        .BUS_WAKE_WDOG_START(BUS_WAKE_WDOG_START),
        .MAIN_OVER_RESET_EN(MAIN_OVER_RESET_EN), .UV_COUNT(UV_COUNT)
    );
    ssw_host u_ssw_host (.mclk(MCLK), .cmd(CMD), .clr(CLR));
    // ==========================================================
    task automatic chk(input string n, input logic [13:0] s, e);
        checks_done++;
        num_errors += (s !== e);
        if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    endtask
    // interrupt is a one-cycle pulse, so every tick collects it
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK) #1 seen |= INT_PULSE;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        CMP.sup_por_ok = 1'b1;
        tick(8);
        chk("init", {MODE, RESET_OUTPUT_N}, {M_INIT, 1'b0});
        @(posedge MCLK) RST_B <= 1'b1;
        tick(RD + 8);
        chk("up", {RESET_OUTPUT_N, LONG_WIN, BUS_WAKE_WDOG_START}, 3'h7);
        chk("main on", MAIN_ON, 1);
        u_ssw_host.off_seq();
        chk("off", {MODE, WDOG_OFF}, {M_STOP, 1'b1});
        chk("bits", {STOP_WDOG_OFF_FIRST, STOP_WDOG_OFF_SECOND}, 2'h3);
        u_ssw_host.wr(2, 1'b0);
        chk("on", {WDOG_OFF, STOP_WDOG_OFF_SECOND, LONG_WIN}, 3'h1);
        chk("first", STOP_WDOG_OFF_FIRST, 0);
        u_ssw_host.off_seq();
        @(posedge MCLK) CAN_WAKE <= 1'b1;
        tick(6);
        chk("wake", {seen, RXD_LOW, LONG_WIN}, 3'h7);
        u_ssw_host.wr(4, 1'b0);
        @(posedge MCLK) {AUX_REQ, CMP.sup_low, CMP.main_warn} <= 3'h7;
        tick(4);
        chk("vs", {FLAGS.supply_under_flag, AUX_EN}, 2'b10);
        chk("warn", {MODE, FLAGS.main_reg_prewarn}, {M_NORMAL, 1'b1});
        u_ssw_host.pulse('0, 14'h1000);
        chk("hold", FLAGS.supply_under_flag, 1);
        @(posedge MCLK) {CMP.sup_low, CMP.main_low} <= 2'b01;
        tick(4);
        chk("uv", {MODE, RESET_OUTPUT_N, UV_COUNT}, {M_RESTART, 4'h1});
        @(posedge MCLK) CMP.main_low <= 1'b0;
        tick(RD + 6);
        u_ssw_host.pulse('0, 14'h0100);
        chk("cnt", {MODE, UV_COUNT}, {M_NORMAL, 3'h0});
        u_ssw_host.wr(1, 1'b1);
        chk("err", STOP_WDOG_OFF_SECOND, 0);
        u_ssw_host.wr(3, 1'b1);
        @(posedge MCLK) {CONFIG_SELECT_INPUT, CMP.main_high} <= 2'b11;
        tick(4);
        chk("ov", {MODE, FAIL_OUTPUTS}, {M_RESTART, 1'b1});
        chk("ovf", FLAGS.main_reg_over, 1);
        tick(RD + 4);
        chk("back", {MODE, MAIN_OVER_RESET_EN}, {M_NORMAL, 1'b0});
        // main rail stuck low: restart first, then the short timer trips
        @(posedge MCLK) CMP.main_low <= 1'b1;
        tick(12);
        chk("sc", {MODE, MAIN_ON}, {M_FAILSAFE, 1'b0});
        chk("scf", FLAGS.main_reg_short, 1);
        @(posedge MCLK) {CMP.main_low, WAKE_INPUTS} <= 2'b01;
        tick(4);
        chk("wk", {MODE, MAIN_ON}, {M_RESTART, 1'b1});
        end_of_test();
    end
endmodule
